// ==== hdl/pwmpm_pin_mux.sv ====
`timescale 1ns/1ps
module pwmpm_pin_mux
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_config_word_3_high,
  input wire logic [7:0] i_config_word_3_low,
  input wire logic [1:0] i_ext_bus_address_width,
  input wire logic [7:0] i_u1_ccp_control_reg,
  input wire logic [7:0] i_u2_ccp_control_reg,
  input wire logic [7:0] i_u3_ccp_control_reg,
  input wire logic [3:0] i_u1_pwm_out,
  input wire logic [3:0] i_u2_pwm_out,
  input wire logic [3:0] i_u3_pwm_out,
  input wire logic i_cmp4_active,
  input wire logic i_cmp4_out,
  input wire logic i_cmp5_active,
  input wire logic i_cmp5_out,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_ebus_addr_out,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_port_latch,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_direction_bits,
  output logic [pwmpm_pkg::NPIN-1:0] o_pin_out,
  output logic [pwmpm_pkg::NPIN-1:0] o_pin_oe,
  output logic [pwmpm_pkg::NPIN-1:0] o_pin_pwm_owned,
  output logic [pwmpm_pkg::NPIN-1:0] o_pin_ebus_owned,
  output logic o_u13_single_output,
  output logic [4:0] o_addr_bits,
  output logic o_routing_ready
);
  import pwmpm_pkg::*;

  logic cfg_u2_sel;
  logic cfg_u13_sel;
  logic [1:0] cfg_pmm;
  logic [1:0] cfg_abw;
  logic cfg_ready;

  logic [NPIN-1:0] pin_out;
  logic [NPIN-1:0] pin_oe;
  logic [NPIN-1:0] pwm_owned;
  logic [NPIN-1:0] ebus_owned;
  logic u13_single;
  logic [4:0] addr_bits;
  logic routing_ready;
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] next_pin_oe;
  logic [NPIN-1:0] next_pwm_owned;
  logic [NPIN-1:0] next_ebus_owned;
  logic next_u13_single;
  logic [4:0] next_addr_bits;
  logic next_routing_ready;

  logic micro_mode;
  logic [3:0] mask_u1;
  logic [3:0] mask_u2;
  logic [3:0] mask_u3;
  logic [NPIN-1:0] addr_claim;

  // ---------------------------------------------------------------
  // Configuration captured at reset release
  // ---------------------------------------------------------------
  pwmpm_cfg_hold i_pwmpm_cfg_hold
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_config_word_3_high(i_config_word_3_high),
    .i_config_word_3_low(i_config_word_3_low),
    .i_ext_bus_address_width(i_ext_bus_address_width),
    .o_unit2_pin_select_bit(cfg_u2_sel),
    .o_unit13_pin_select_bit(cfg_u13_sel),
    .o_prog_mem_mode(cfg_pmm),
    .o_ext_bus_address_width(cfg_abw),
    .o_ready(cfg_ready)
  );

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Outputs a unit drives in its current mode
  function automatic logic [3:0] used_mask(input logic [7:0] ctrl);
    logic [3:0] m;
    m = OUT_MASK_NONE;
    if (ctrl[CTRL_MODE_LSB+2 +: 2] == MODE_PWM_TOP)
    begin
      case (ctrl[CTRL_OCF_LSB +: 2])
        OCF_SINGLE: m = OUT_MASK_A;
        OCF_HALF: m = OUT_MASK_AB;
        OCF_FULL_FWD: m = OUT_MASK_ABCD;
        OCF_FULL_REV: m = OUT_MASK_ABCD;
        default: m = OUT_MASK_NONE;
      endcase
    end
    return m;
  endfunction

  // Address lines in use for a width code
  function automatic logic [4:0] width_bits(input logic [1:0] abw);
    logic [4:0] w;
    w = 5'h08;
    if (abw == ABW_8)
      w = 5'h08;
    else if (abw == ABW_12)
      w = 5'h0C;
    else if (abw == ABW_16)
      w = 5'h10;
    else
      w = 5'h14;
    return w;
  endfunction

  // Pins claimed as address lines for a width code
  function automatic logic [NPIN-1:0] width_pins(input logic [1:0] abw);
    logic [NPIN-1:0] p;
    p = ADDR8_PIN_MASK;
    if (abw == ABW_20)
      p = ADDR20_PIN_MASK;
    else if (abw == ABW_16)
      p = ADDR16_PIN_MASK;
    else if (abw == ABW_12)
      p = ADDR12_PIN_MASK;
    else
      p = ADDR8_PIN_MASK;
    return p;
  endfunction

  // ---------------------------------------------------------------
  // Mode and ownership decode
  // ---------------------------------------------------------------
  always_comb
  begin
    micro_mode = (cfg_pmm == PMM_MICRO);
    next_u13_single = cfg_u13_sel && !micro_mode;
    next_addr_bits = width_bits(cfg_abw);
    addr_claim = micro_mode ? '0 : width_pins(cfg_abw);
    mask_u2 = used_mask(i_u2_ccp_control_reg);
    mask_u1 = used_mask(i_u1_ccp_control_reg);
    mask_u3 = used_mask(i_u3_ccp_control_reg);
    if (next_u13_single)
    begin
      mask_u1 = mask_u1 & OUT_MASK_A;
      mask_u3 = mask_u3 & OUT_MASK_A;
    end
  end

  // ---------------------------------------------------------------
  // Pin routing
  // ---------------------------------------------------------------
  always_comb
  begin
    next_pin_out = i_port_latch;
    next_pwm_owned = '0;
    next_ebus_owned = '0;
    next_routing_ready = cfg_ready;

    // Unit two output A, one of three pins
    if (mask_u2[0])
    begin
      if (cfg_u2_sel && micro_mode)
      begin
        next_pin_out[PIN_C1] = i_u2_pwm_out[0];
        next_pwm_owned[PIN_C1] = 1'b1;
      end
      else if (micro_mode)
      begin
        next_pin_out[PIN_E7] = i_u2_pwm_out[0];
        next_pwm_owned[PIN_E7] = 1'b1;
      end
      else
      begin
        next_pin_out[PIN_B3] = i_u2_pwm_out[0];
        next_pwm_owned[PIN_B3] = 1'b1;
      end
    end

    // Unit two B-D on dedicated pins
    if (mask_u2[1])
    begin
      next_pin_out[PIN_U2B] = i_u2_pwm_out[1];
      next_pwm_owned[PIN_U2B] = 1'b1;
    end
    if (mask_u2[2])
    begin
      next_pin_out[PIN_U2C] = i_u2_pwm_out[2];
      next_pwm_owned[PIN_U2C] = 1'b1;
    end
    if (mask_u2[3])
    begin
      next_pin_out[PIN_U2D] = i_u2_pwm_out[3];
      next_pwm_owned[PIN_U2D] = 1'b1;
    end

    // Units one and three, A-C dedicated
    for (int k = 0; k < 3; k++)
    begin
      if (mask_u1[k])
      begin
        next_pin_out[PIN_U1A+k] = i_u1_pwm_out[k];
        next_pwm_owned[PIN_U1A+k] = 1'b1;
      end
      if (mask_u3[k])
      begin
        next_pin_out[PIN_U3A+k] = i_u3_pwm_out[k];
        next_pwm_owned[PIN_U3A+k] = 1'b1;
      end
    end

    // Shared D pins, compare unit first
    if (i_cmp5_active)
      next_pin_out[PIN_U1D_CMP5] = i_cmp5_out;
    else if (mask_u1[3])
    begin
      next_pin_out[PIN_U1D_CMP5] = i_u1_pwm_out[3];
      next_pwm_owned[PIN_U1D_CMP5] = 1'b1;
    end
    if (i_cmp4_active)
      next_pin_out[PIN_U3D_CMP4] = i_cmp4_out;
    else if (mask_u3[3])
    begin
      next_pin_out[PIN_U3D_CMP4] = i_u3_pwm_out[3];
      next_pwm_owned[PIN_U3D_CMP4] = 1'b1;
    end

    // Address lines override on claimed pins
    for (int p = 0; p < NPIN; p++)
    begin
      if (addr_claim[p])
      begin
        next_pin_out[p] = i_ebus_addr_out[p];
        next_pwm_owned[p] = 1'b0;
        next_ebus_owned[p] = 1'b1;
      end
    end

    // Drivers follow direction bits, bus lines always driven
    next_pin_oe = ~i_direction_bits | next_ebus_owned;

    // Quiet pins until configuration is held
    if (!cfg_ready)
    begin
      next_pin_out = '0;
      next_pin_oe = '0;
      next_pwm_owned = '0;
      next_ebus_owned = '0;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      pin_out <= '0;
      pin_oe <= '0;
      pwm_owned <= '0;
      ebus_owned <= '0;
      u13_single <= 1'b0;
      addr_bits <= 5'h00;
      routing_ready <= 1'b0;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pwm_owned <= next_pwm_owned;
      ebus_owned <= next_ebus_owned;
      u13_single <= next_u13_single;
      addr_bits <= next_addr_bits;
      routing_ready <= next_routing_ready;
    end
  end

  assign o_pin_out = pin_out;
  assign o_pin_oe = pin_oe;
  assign o_pin_pwm_owned = pwm_owned;
  assign o_pin_ebus_owned = ebus_owned;
  assign o_u13_single_output = u13_single;
  assign o_addr_bits = addr_bits;
  assign o_routing_ready = routing_ready;

endmodule

// ==== hdl/pwmpm_pkg.sv ====
package pwmpm_pkg;

  // ---------------------------------------------------------------
  // Pin map of the shared pins
  // ---------------------------------------------------------------
  localparam int NPIN = 14;
  localparam int PIN_C1 = 0;
  localparam int PIN_E7 = 1;
  localparam int PIN_B3 = 2;
  localparam int PIN_U2B = 3;
  localparam int PIN_U2C = 4;
  localparam int PIN_U2D = 5;
  localparam int PIN_U1A = 6;
  localparam int PIN_U1B = 7;
  localparam int PIN_U1C = 8;
  localparam int PIN_U1D_CMP5 = 9;
  localparam int PIN_U3A = 10;
  localparam int PIN_U3B = 11;
  localparam int PIN_U3C = 12;
  localparam int PIN_U3D_CMP4 = 13;

  // ---------------------------------------------------------------
  // Configuration word fields
  // ---------------------------------------------------------------
  localparam int CFG3H_U2_SEL_BIT = 0;
  localparam int CFG3H_U13_SEL_BIT = 1;
  localparam int CFG3L_PMM_LSB = 0;
  localparam int CFG3L_PMM_W = 2;
  localparam logic [1:0] PMM_MICRO = 2'h3;
  localparam logic [1:0] ABW_8 = 2'h0;
  localparam logic [1:0] ABW_12 = 2'h1;
  localparam logic [1:0] ABW_16 = 2'h2;
  localparam logic [1:0] ABW_20 = 2'h3;
  localparam logic [7:0] CFG3H_RESET = 8'h03;
  localparam logic [7:0] CFG3L_RESET = 8'h03;
  localparam logic [1:0] ABW_RESET = 2'h3;

  // Pins taken by upper address lines at 20-bit addressing
  localparam logic [NPIN-1:0] ADDR20_PIN_MASK = 14'h1980;
  localparam logic [NPIN-1:0] ADDR16_PIN_MASK = 14'h0000;
  localparam logic [NPIN-1:0] ADDR12_PIN_MASK = 14'h0000;
  localparam logic [NPIN-1:0] ADDR8_PIN_MASK = 14'h0000;

  // ---------------------------------------------------------------
  // Control register fields of each enhanced unit
  // ---------------------------------------------------------------
  localparam int CTRL_OCF_LSB = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [1:0] OCF_SINGLE = 2'h0;
  localparam logic [1:0] OCF_FULL_FWD = 2'h1;
  localparam logic [1:0] OCF_HALF = 2'h2;
  localparam logic [1:0] OCF_FULL_REV = 2'h3;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [3:0] OUT_MASK_NONE = 4'h0;
  localparam logic [3:0] OUT_MASK_A = 4'h1;
  localparam logic [3:0] OUT_MASK_AB = 4'h3;
  localparam logic [3:0] OUT_MASK_ABCD = 4'hF;

  // Configuration sampler states
  typedef enum logic [1:0] {
    ST_RESET = 2'b01,
    ST_RUN = 2'b10
  } pwmpm_state_t;

endpackage

// ==== hdl/pwmpm_cfg_hold.sv ====
`timescale 1ns/1ps
module pwmpm_cfg_hold
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_config_word_3_high,
  input wire logic [7:0] i_config_word_3_low,
  input wire logic [1:0] i_ext_bus_address_width,
  output logic o_unit2_pin_select_bit,
  output logic o_unit13_pin_select_bit,
  output logic [1:0] o_prog_mem_mode,
  output logic [1:0] o_ext_bus_address_width,
  output logic o_ready
);
  import pwmpm_pkg::*;

  pwmpm_state_t state;
  pwmpm_state_t next_state;
  logic [7:0] cfg_hi;
  logic [7:0] cfg_lo;
  logic [1:0] abw;
  logic [7:0] next_cfg_hi;
  logic [7:0] next_cfg_lo;
  logic [1:0] next_abw;

  // ---------------------------------------------------------------
  // Capture once at reset release, then hold
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_cfg_hi = cfg_hi;
    next_cfg_lo = cfg_lo;
    next_abw = abw;
    case (state)
      ST_RESET:
      begin
        next_cfg_hi = i_config_word_3_high;
        next_cfg_lo = i_config_word_3_low;
        next_abw = i_ext_bus_address_width;
        next_state = ST_RUN;
      end
      ST_RUN:
      begin
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state <= ST_RESET;
      cfg_hi <= CFG3H_RESET;
      cfg_lo <= CFG3L_RESET;
      abw <= ABW_RESET;
    end
    else
    begin
      state <= next_state;
      cfg_hi <= next_cfg_hi;
      cfg_lo <= next_cfg_lo;
      abw <= next_abw;
    end
  end

  assign o_unit2_pin_select_bit = cfg_hi[CFG3H_U2_SEL_BIT];
  assign o_unit13_pin_select_bit = cfg_hi[CFG3H_U13_SEL_BIT];
  assign o_prog_mem_mode = cfg_lo[CFG3L_PMM_LSB +: CFG3L_PMM_W];
  assign o_ext_bus_address_width = abw;
  assign o_ready = (state == ST_RUN);

endmodule

// ==== tb/pwmpm_chk.sv ====
`timescale 1ns/1ps
module pwmpm_chk
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_config_word_3_high,
  input wire logic [7:0] i_config_word_3_low,
  input wire logic [1:0] i_ext_bus_address_width,
  input wire logic [7:0] i_u2_ccp_control_reg,
  input wire logic [3:0] i_u2_pwm_out,
  input wire logic i_cmp5_active,
  input wire logic i_cmp5_out,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_port_latch,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_direction_bits,
  input wire logic [pwmpm_pkg::NPIN-1:0] o_pin_out,
  input wire logic [pwmpm_pkg::NPIN-1:0] o_pin_oe,
  input wire logic [pwmpm_pkg::NPIN-1:0] o_pin_pwm_owned,
  input wire logic [pwmpm_pkg::NPIN-1:0] o_pin_ebus_owned,
  input wire logic o_u13_single_output,
  input wire logic [4:0] o_addr_bits,
  input wire logic o_routing_ready
);
  import pwmpm_pkg::*;
  localparam logic [NPIN-1:0] FREE_M = 14'h1DFF;
  logic rst_q;
  logic [7:0] cap_h;
  logic [7:0] cap_l;
  logic [1:0] cap_w;
  logic micro;
  int u2p;
  // ---------------------------------------------------------------
  // Configuration copy taken at reset release
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    rst_q <= i_rst;
    if (rst_q && !i_rst)
    begin
      cap_h <= i_config_word_3_high;
      cap_l <= i_config_word_3_low;
      cap_w <= i_ext_bus_address_width;
    end
  end
  assign micro = cap_l[1:0] == PMM_MICRO;
  assign u2p = micro ? (cap_h[0] ? PIN_C1 : PIN_E7) : PIN_B3;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  rst_clear_a: assert property ($fell(i_rst) |-> o_pin_oe == '0 &&
    o_pin_out == '0 && !o_routing_ready) else $error("outputs not clear");
  ready_seq_a: assert property ($fell(i_rst) |=>
    !o_routing_ready ##1 o_routing_ready) else $error("ready timing");
  ready_hold_a: assert property (o_routing_ready |=>
    o_routing_ready) else $error("ready dropped");
  oe_dir_a: assert property (o_routing_ready |-> o_pin_oe ==
    (~$past(i_direction_bits) | o_pin_ebus_owned)) else $error("oe wrong");
  latch_free_a: assert property (o_routing_ready |->
    ((o_pin_out ^ $past(i_port_latch)) & FREE_M &
    ~(o_pin_pwm_owned | o_pin_ebus_owned)) == '0) else $error("latch");
  u2_route_a: assert property (o_routing_ready &&
    $past(i_u2_ccp_control_reg[3:2]) == 2'h3 |-> o_pin_pwm_owned[u2p] &&
    o_pin_out[u2p] == $past(i_u2_pwm_out[0])) else $error("u2 route");
  cmp5_wins_a: assert property (o_routing_ready &&
    $past(i_cmp5_active) |-> o_pin_out[PIN_U1D_CMP5] == $past(i_cmp5_out) &&
    !o_pin_pwm_owned[PIN_U1D_CMP5]) else $error("cmp5 priority");
  single_a: assert property (o_routing_ready |->
    o_u13_single_output == (cap_h[1] && !micro)) else $error("single");
  claim_a: assert property (o_routing_ready |->
    o_pin_ebus_owned == (!micro && cap_w == ABW_20 ? ADDR20_PIN_MASK : '0))
    else $error("claim");
  width_a: assert property (o_routing_ready |->
    o_addr_bits == 5'(8 + 4 * cap_w)) else $error("addr width");
  ready_c: cover property ($fell(i_rst) ##2 o_routing_ready);
  cmp5_c: cover property (o_routing_ready && $past(i_cmp5_active));
  single_c: cover property (o_routing_ready && o_u13_single_output);
  claim_c: cover property (o_routing_ready && o_pin_ebus_owned != '0);
endmodule

// ==== tb/pwmpm_far_model.sv ====
`timescale 1ns/1ps
module pwmpm_far_model
(
  input wire logic i_mclk,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_pin_out,
  input wire logic [pwmpm_pkg::NPIN-1:0] i_pin_oe,
  output logic [3:0] o_u1_pwm,
  output logic [3:0] o_u2_pwm,
  output logic [3:0] o_u3_pwm,
  output logic [pwmpm_pkg::NPIN-1:0] o_pin_level
);
  logic [7:0] cnt = 8'h00;
  // PWM levels move every cycle, off the sampling edge
  always @(negedge i_mclk)
    cnt <= cnt + 8'h01;
  assign o_u1_pwm = cnt[3:0];
  assign o_u2_pwm = ~cnt[3:0];
  assign o_u3_pwm = {cnt[0], cnt[3:1]};
  // Undriven pins float high through pull-ups
  assign o_pin_level = (i_pin_oe & i_pin_out) | ~i_pin_oe;
endmodule

// ==== tb/pwmpm_pin_mux_tb_top.sv ====
`timescale 1ns/1ps
bind pwmpm_pin_mux pwmpm_chk i_pwmpm_chk (.i_mclk, .i_rst,
  .i_config_word_3_high, .i_config_word_3_low, .i_ext_bus_address_width,
  .i_u2_ccp_control_reg, .i_u2_pwm_out, .i_cmp5_active, .i_cmp5_out,
  .i_port_latch, .i_direction_bits, .o_pin_out, .o_pin_oe,
  .o_pin_pwm_owned, .o_pin_ebus_owned, .o_u13_single_output,
  .o_addr_bits, .o_routing_ready);
module pwmpm_pin_mux_tb_top;
  import pwmpm_pkg::*;
  logic i_mclk = 0;
  logic i_rst = 1;
  logic [7:0] cfg_h = 8'h03, cfg_l = 8'h03, c1 = 8'h4C, c2 = 8'h4C;
  logic [1:0] cfg_w = 2'h3;
  logic c4a = 0, c4o = 0, c5a = 0, c5o = 0;
  logic [NPIN-1:0] ea = 14'h1555, latch = 14'h2AAA, dir = '0;
  logic [NPIN-1:0] p_out, p_oe, lvl;
  logic [3:0] u1, u2, u3, m2 = 4'hF, m13 = 4'hF;
  logic [11:0] snap;
  logic [4:0] abits;
  logic single_o, rdy, sel, micro, single, w20;
  int u2p, n_fail = 0, checks = 0;
  initial forever #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) snap <= {u3, u2, u1};
  pwmpm_pin_mux i_pwmpm_pin_mux (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_config_word_3_high(cfg_h), .i_config_word_3_low(cfg_l),
    .i_ext_bus_address_width(cfg_w), .i_u1_ccp_control_reg(c1),
    .i_u2_ccp_control_reg(c2), .i_u3_ccp_control_reg(c1),
    .i_u1_pwm_out(u1), .i_u2_pwm_out(u2), .i_u3_pwm_out(u3),
    .i_cmp4_active(c4a), .i_cmp4_out(c4o), .i_cmp5_active(c5a),
    .i_cmp5_out(c5o), .i_ebus_addr_out(ea), .i_port_latch(latch),
    .i_direction_bits(dir), .o_pin_out(p_out), .o_pin_oe(p_oe),
    .o_pin_pwm_owned(), .o_pin_ebus_owned(), .o_u13_single_output(single_o),
    .o_addr_bits(abits), .o_routing_ready(rdy));
  pwmpm_far_model i_pwmpm_far_model (.i_mclk(i_mclk), .i_pin_out(p_out),
    .i_pin_oe(p_oe), .o_u1_pwm(u1), .o_u2_pwm(u2), .o_u3_pwm(u3),
    .o_pin_level(lvl));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [13:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] h, l, input logic [1:0] w);
    @(negedge i_mclk);
    i_rst = 1;
    cfg_h = h;
    cfg_l = l;
    cfg_w = w;
    sel = h[0];
    micro = l[1:0] == PMM_MICRO;
    single = h[1] && !micro;
    w20 = !micro && w == ABW_20;
    u2p = micro ? (sel ? PIN_C1 : PIN_E7) : PIN_B3;
    repeat (20) @(negedge i_mclk);
    i_rst = 0;
    for (int k = 0; k < 5 && rdy !== 1'b1; k++) @(negedge i_mclk);
    if (rdy !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] routing_ready exp 1 got %b", rdy);
      report_and_stop();
    end
    else
    begin
      chk("addr_bits", 14'(8 + 4 * w), 14'(abits));
      chk("single", 14'(single), 14'(single_o));
    end
  endtask
  function automatic logic [13:0] exp_out(input logic [11:0] s);
    logic [13:0] e;
    e = latch;
    for (int k = 0; k < 4; k++)
      if (m2[k])
        e[k ? 2 + k : u2p] = s[4 + k];
    if (m13[0])
    begin
      e[PIN_U1A] = s[0];
      e[PIN_U3A] = s[8];
    end
    for (int k = 1; k < 4; k++)
      if (m13[k] && !single)
      begin
        e[PIN_U1A + k] = s[k];
        e[PIN_U3A + k] = s[8 + k];
      end
    if (c5a)
      e[PIN_U1D_CMP5] = c5o;
    if (c4a)
      e[PIN_U3D_CMP4] = c4o;
    if (w20)
      e = (e & ~ADDR20_PIN_MASK) | (ea & ADDR20_PIN_MASK);
    return e;
  endfunction
  task automatic run_chk(input int n);
    logic [13:0] oe, eo;
    repeat (n)
    begin
      @(negedge i_mclk);
      oe = ~dir | (w20 ? ADDR20_PIN_MASK : '0);
      eo = exp_out(snap);
      chk("pin_out", eo, p_out);
      chk("pin_oe", oe, p_oe);
      chk("pin_level", (oe & eo) | ~oe, lvl);
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_default;
    do_reset(8'h03, 8'h03, 2'h3);
    for (int k = 0; k < 4; k++)
    begin
      c2 = {2'(k), 6'h0C};
      m2 = k == 0 ? 4'h1 : k == 2 ? 4'h3 : 4'hF;
      run_chk(4);
    end
    c2 = 8'h44;
    m2 = 4'h0;
    c1 = 8'h44;
    m13 = 4'h0;
    run_chk(2);
    c1 = 8'h8C;
    m13 = 4'h3;
    run_chk(2);
    c1 = 8'h4C;
    m13 = 4'hF;
    c2 = 8'h4C;
    m2 = 4'hF;
    dir = 14'h0009;
    run_chk(3);
    dir = '0;
    $display("test default done");
  endtask
  task automatic t_modes;
    do_reset(8'h02, 8'h03, 2'h3);
    run_chk(4);
    do_reset(8'h00, 8'h00, 2'h2);
    run_chk(2);
    c5a = 1;
    c5o = 1;
    c4a = 1;
    run_chk(2);
    c5o = 0;
    c4o = 1;
    run_chk(2);
    c4a = 0;
    c5a = 0;
    for (int w = 0; w < 3; w++)
    begin
      do_reset(8'h00, 8'h02, 2'(w));
      run_chk(2);
    end
    $display("test modes done");
  endtask
  task automatic t_single;
    do_reset(8'h03, 8'h01, 2'h3);
    dir = ADDR20_PIN_MASK;
    run_chk(4);
    c5a = 1;
    c5o = 1;
    run_chk(2);
    c5a = 0;
    dir = '0;
    $display("test single done");
  endtask
  task automatic t_frozen;
    do_reset(8'h03, 8'h03, 2'h3);
    cfg_h = 8'h00;
    cfg_l = 8'h00;
    run_chk(4);
    $display("test frozen done");
  endtask
  initial
  begin
    t_default();
    t_modes();
    t_single();
    t_frozen();
    report_and_stop();
  end
endmodule
